// ===== shared/usb_port_iso_pkg.sv
// Package: register map, field positions, reset values and types of the port/iso block
package usb_port_iso_pkg;

  localparam logic [11:0] PORT_STATUS_CONTROL_OFS = 12'h064;
  localparam logic [11:0] ISO_COMPLETION_MAP_OFS  = 12'h130;
  localparam logic [11:0] ISO_BYPASS_MAP_OFS      = 12'h134;
  localparam logic [11:0] ISO_FINAL_SLOT_MAP_OFS  = 12'h138;
  localparam logic [11:0] ROUTING_CONFIG_REG_OFS  = 12'h060;
  localparam logic [11:0] STRUCTURAL_PARAMS_OFS   = 12'h004;

  localparam int TEST_SEL_LSB  = 16;
  localparam int INDICATOR_LSB = 14;
  localparam int HANDOFF_BIT   = 13;
  localparam int VBUS_BIT      = 12;
  localparam int DP_BIT        = 11;
  localparam int DM_BIT        = 10;
  localparam int BUS_RESET_BIT = 8;
  localparam int SLEEP_BIT     = 7;
  localparam int RESUME_BIT    = 6;
  localparam int ENABLE_BIT    = 2;
  localparam int ATTACH_CHG_BIT = 1;
  localparam int ATTACH_BIT    = 0;
  localparam int PSC_CAP_BIT   = 4;
  localparam int IND_CAP_BIT   = 16;

  localparam logic [31:0] COMPLETION_RST = 32'h00000000;
  localparam logic [31:0] BYPASS_RST     = 32'hffffffff;
  localparam logic [31:0] FINAL_RST      = 32'h00000000;

  typedef struct packed {
    logic [3:0] test_select;
    logic [1:0] indicator;
    logic       handoff;
    logic       vbus;
    logic       bus_reset;
    logic       sleep;
    logic       resume;
    logic       enable;
    logic       attach_chg;
    logic       attach;
  } port_state_t;

  typedef struct packed {
    logic       dp;
    logic       dm;
    logic       attach;
    logic       bus_reset;
    logic       sleep;
    logic       resume;
  } line_in_t;

  typedef enum logic [1:0] {
    SCAN_IDLE  = 2'b00,
    SCAN_CHECK = 2'b01,
    SCAN_WAIT  = 2'b10
  } scan_state_t;

endpackage

// ===== src/usb_port_status_iso_ptd_maps.sv
// Port status/control register and isochronous descriptor maps with APB slave and scan walker
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module usb_port_status_iso_ptd_maps #(
  parameter int SLOTS = 32
) (
  input  wire logic                           ref_clk,
  input  wire logic                           sys_rst,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [11:0]                    paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire usb_port_iso_pkg::line_in_t     line_in,
  input  wire logic                           indicator_capable,
  input  wire logic                           power_switch_capable,
  input  wire logic                           slot_valid,
  input  wire logic [4:0]                     next_descriptor_link,
  input  wire logic                           link_follow,
  input  wire logic                           slot_done,
  input  wire logic [4:0]                     done_slot,
  input  wire logic                           scan_start,
  output logic                                slot_go,
  output logic      [4:0]                     slot_index,
  output logic      [3:0]                     port_test_select,
  output logic      [1:0]                     indicator_drive_field,
  output logic                                companion_handoff_flag,
  output logic                                vbus_switch_bit,
  output logic                                link_enable,
  output logic                                config_done_bit,
  output logic                                scan_wrap
);

  usb_port_iso_pkg::port_state_t port_r;
  usb_port_iso_pkg::scan_state_t scan_r;
  logic [31:0] done_map_r;
  logic [31:0] bypass_map_r;
  logic [31:0] final_map_r;
  logic        cfg_r;
  logic        prev_attach_r;
  logic [4:0]  idx_r;
  logic [31:0] rdata_nxt;
  logic [31:0] port_view;
  logic        wr_en;
  logic        rd_en;
  logic        hit;
  logic        powered;
  logic        psc_dont_care;
  logic        sel_psc;
  logic        sel_done;
  logic        sel_byp;
  logic        sel_fin;
  logic        sel_cfg;
  logic        sel_cap;
  logic        psc_wr;
  logic        cfg_wr;
  logic        byp_wr;
  logic        fin_wr;
  logic        done_rd;
  logic        attach_edge;
  logic        at_end;
  logic        go_nxt;
  logic        wrap_nxt;
  logic [4:0]  idx_nxt;
  logic [31:0] cap_view;
  usb_port_iso_pkg::scan_state_t scan_nxt;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign powered = port_r.vbus;
  assign psc_dont_care = power_switch_capable;

  // Address match shared by read mux and write strobes
  assign sel_psc  = paddr == usb_port_iso_pkg::PORT_STATUS_CONTROL_OFS;
  assign sel_done = paddr == usb_port_iso_pkg::ISO_COMPLETION_MAP_OFS;
  assign sel_byp  = paddr == usb_port_iso_pkg::ISO_BYPASS_MAP_OFS;
  assign sel_fin  = paddr == usb_port_iso_pkg::ISO_FINAL_SLOT_MAP_OFS;
  assign sel_cfg  = paddr == usb_port_iso_pkg::ROUTING_CONFIG_REG_OFS;
  assign sel_cap  = paddr == usb_port_iso_pkg::STRUCTURAL_PARAMS_OFS;
  assign psc_wr   = wr_en && sel_psc;
  assign cfg_wr   = wr_en && sel_cfg;
  assign byp_wr   = wr_en && sel_byp;
  assign fin_wr   = wr_en && sel_fin;
  assign done_rd  = rd_en && sel_done;
  assign attach_edge = line_in.attach != prev_attach_r;

  always_comb begin
    cap_view = 32'h00000000;
    cap_view[usb_port_iso_pkg::IND_CAP_BIT] = indicator_capable;
    cap_view[usb_port_iso_pkg::PSC_CAP_BIT] = psc_dont_care;
  end

  // Reads of gated fields return zero when the port is unpowered
  always_comb begin
    port_view = '0;
    port_view[usb_port_iso_pkg::TEST_SEL_LSB +: 4] = port_r.test_select;
    port_view[usb_port_iso_pkg::HANDOFF_BIT] = port_r.handoff;
    port_view[usb_port_iso_pkg::VBUS_BIT] = port_r.vbus;
    port_view[usb_port_iso_pkg::DP_BIT] = line_in.dp;
    port_view[usb_port_iso_pkg::DM_BIT] = line_in.dm;
    if (powered) begin
      port_view[usb_port_iso_pkg::INDICATOR_LSB +: 2] = port_r.indicator;
      port_view[usb_port_iso_pkg::BUS_RESET_BIT] = port_r.bus_reset;
      port_view[usb_port_iso_pkg::SLEEP_BIT] = port_r.sleep;
      port_view[usb_port_iso_pkg::RESUME_BIT] = port_r.resume;
      port_view[usb_port_iso_pkg::ENABLE_BIT] = port_r.enable;
      port_view[usb_port_iso_pkg::ATTACH_CHG_BIT] = port_r.attach_chg;
      port_view[usb_port_iso_pkg::ATTACH_BIT] = port_r.attach;
    end
  end

  always_comb begin
    rdata_nxt = 32'h00000000;
    hit = 1'b1;
    if (sel_psc) begin
      rdata_nxt = port_view;
    end else if (sel_done) begin
      rdata_nxt = done_map_r;
    end else if (sel_byp) begin
      rdata_nxt = bypass_map_r;
    end else if (sel_fin) begin
      rdata_nxt = final_map_r;
    end else if (sel_cfg) begin
      rdata_nxt = {31'h00000000, cfg_r};
    end else if (sel_cap) begin
      rdata_nxt = cap_view;
    end else begin
      hit = 1'b0;
    end
  end

  // Zero-wait slave: ready in the access cycle, data registered from setup
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !hit;
    end
  end

  // Captured at setup; the completion clear uses it as its mask
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= (psel && !penable && !pwrite) ? rdata_nxt : 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_r <= 1'b0;
    end else if (cfg_wr) begin
      cfg_r <= pwdata[0];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_attach_r <= 1'b0;
    end else begin
      prev_attach_r <= line_in.attach;
    end
  end

  // Port register: reset only by the controller reset
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_r         <= '0;
      port_r.handoff <= 1'b1;
    end else begin
      port_r.attach    <= line_in.attach;
      port_r.bus_reset <= line_in.bus_reset;
      port_r.sleep     <= line_in.sleep;
      port_r.resume    <= line_in.resume;
      if (psc_wr) begin
        port_r.test_select <= pwdata[usb_port_iso_pkg::TEST_SEL_LSB +: 4];
        port_r.vbus        <= pwdata[usb_port_iso_pkg::VBUS_BIT];
        port_r.enable      <= pwdata[usb_port_iso_pkg::ENABLE_BIT];
        if (indicator_capable) begin
          port_r.indicator <= pwdata[usb_port_iso_pkg::INDICATOR_LSB +: 2];
        end
        port_r.handoff <= pwdata[usb_port_iso_pkg::HANDOFF_BIT];
        if (pwdata[usb_port_iso_pkg::ATTACH_CHG_BIT]) begin
          port_r.attach_chg <= 1'b0;
        end
      end
      // Change wins over a software clear in the same cycle
      if (attach_edge) begin
        port_r.attach_chg <= 1'b1;
      end
      // Forced in the same cycle the config bit drops, so both mirrors agree
      if (!cfg_r || (cfg_wr && !pwdata[0])) begin
        port_r.handoff <= 1'b1;
      end
      if (cfg_wr && !cfg_r && pwdata[0]) begin
        port_r.handoff <= 1'b0;
      end
    end
  end

  // Only bits that were shown are cleared; a bit set after setup survives
  for (genvar s = 0; s < 32; s++) begin : g_done
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        done_map_r[s] <= usb_port_iso_pkg::COMPLETION_RST[s];
      end else if (slot_done && done_slot == 5'(s)) begin
        done_map_r[s] <= 1'b1;
      end else if (done_rd && prdata[s]) begin
        done_map_r[s] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bypass_map_r <= usb_port_iso_pkg::BYPASS_RST;
    end else if (byp_wr) begin
      bypass_map_r <= pwdata;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      final_map_r <= usb_port_iso_pkg::FINAL_RST;
    end else if (fin_wr) begin
      final_map_r <= pwdata;
    end
  end

  assign at_end = final_map_r[idx_r] || idx_r == 5'(SLOTS - 1);

  // Slot walker: checks one slot per step, waits for scheduler on valid slots that are not bypassed
  always_comb begin
    scan_nxt = scan_r;
    idx_nxt  = idx_r;
    go_nxt   = 1'b0;
    wrap_nxt = 1'b0;
    case (scan_r)
      usb_port_iso_pkg::SCAN_IDLE: begin
        if (scan_start) begin
          idx_nxt  = 5'h00;
          scan_nxt = usb_port_iso_pkg::SCAN_CHECK;
        end
      end
      usb_port_iso_pkg::SCAN_CHECK: begin
        if (!bypass_map_r[idx_r] && slot_valid) begin
          go_nxt   = 1'b1;
          scan_nxt = usb_port_iso_pkg::SCAN_WAIT;
        end else if (at_end) begin
          idx_nxt  = 5'h00;
          wrap_nxt = 1'b1;
          scan_nxt = usb_port_iso_pkg::SCAN_IDLE;
        end else begin
          idx_nxt = idx_r + 5'h01;
        end
      end
      usb_port_iso_pkg::SCAN_WAIT: begin
        if (slot_done) begin
          if (at_end) begin
            idx_nxt  = 5'h00;
            wrap_nxt = 1'b1;
            scan_nxt = usb_port_iso_pkg::SCAN_IDLE;
          end else if (link_follow && !bypass_map_r[next_descriptor_link]) begin
            idx_nxt  = next_descriptor_link;
            scan_nxt = usb_port_iso_pkg::SCAN_CHECK;
          end else begin
            idx_nxt  = idx_r + 5'h01;
            scan_nxt = usb_port_iso_pkg::SCAN_CHECK;
          end
        end
      end
      default: begin
        scan_nxt = usb_port_iso_pkg::SCAN_IDLE;
      end
    endcase
  end

  // Index and its output copy load together, so slot_valid always matches idx_r
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scan_r     <= usb_port_iso_pkg::SCAN_IDLE;
      idx_r      <= 5'h00;
      slot_index <= 5'h00;
      slot_go    <= 1'b0;
      scan_wrap  <= 1'b0;
    end else begin
      scan_r     <= scan_nxt;
      idx_r      <= idx_nxt;
      slot_index <= idx_nxt;
      slot_go    <= go_nxt;
      scan_wrap  <= wrap_nxt;
    end
  end

  // Mirrored control outputs, all registered
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_test_select <= 4'h0;
    end else begin
      port_test_select <= port_r.test_select;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      indicator_drive_field <= 2'h0;
    end else begin
      indicator_drive_field <= port_r.indicator;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      companion_handoff_flag <= 1'b1;
    end else begin
      companion_handoff_flag <= port_r.handoff;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vbus_switch_bit <= 1'b0;
    end else begin
      vbus_switch_bit <= port_r.vbus;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_enable <= 1'b0;
    end else begin
      link_enable <= port_r.enable && powered;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      config_done_bit <= 1'b0;
    end else begin
      config_done_bit <= cfg_r;
    end
  end

endmodule // usb_port_status_iso_ptd_maps

// ===== tb/port_iso_checker.sv
// Checker: bus timing, handoff flag, mirrors and scan pulses
`timescale 1ns/1ps
module port_iso_checker #(
  parameter int SLOTS = 32
) (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        slot_go,
  input wire logic        scan_wrap,
  input wire logic [3:0]  port_test_select,
  input wire logic        companion_handoff_flag,
  input wire logic        config_done_bit,
  input wire logic        vbus_switch_bit,
  input wire logic        link_enable
);
  logic wr_psc;
  assign wr_psc = psel && penable && pwrite
                  && paddr == usb_port_iso_pkg::PORT_STATUS_CONTROL_OFS;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  zero_wait_a: assert property (psel && !penable |=> pready)
    else $error("access phase without ready");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held past access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  handoff_hold_a: assert property (!config_done_bit |-> companion_handoff_flag)
    else $error("handoff low while unconfigured");
  handoff_clear_a: assert property ($rose(config_done_bit) |-> !companion_handoff_flag)
    else $error("handoff kept on configure");
  enable_power_a: assert property (link_enable |-> vbus_switch_bit)
    else $error("enable shown without power");
  test_cause_a: assert property ($changed(port_test_select)
    |-> $past(wr_psc, 2) || $past(wr_psc, 3))
    else $error("test select moved without write");
  go_pulse_a: assert property (slot_go |=> !slot_go)
    else $error("slot go longer than a pulse");
  wrap_pulse_a: assert property (scan_wrap |=> !scan_wrap ##1 !scan_wrap)
    else $error("scan wrap repeated");
  cover property (pslverr);
  cover property (scan_wrap);
  cover property ($rose(config_done_bit));
endmodule // port_iso_checker

bind usb_port_status_iso_ptd_maps port_iso_checker #(.SLOTS(SLOTS)) chk_i (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .slot_go(slot_go),
  .scan_wrap(scan_wrap), .port_test_select(port_test_select),
  .companion_handoff_flag(companion_handoff_flag), .config_done_bit(config_done_bit),
  .vbus_switch_bit(vbus_switch_bit), .link_enable(link_enable));

// ===== tb/sched_model.sv
// Scheduler-side model: slot valid bits and delayed completions
`timescale 1ns/1ps
module sched_model (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        slot_go,
  input  wire logic [4:0]  slot_index,
  input  wire logic [31:0] valid_map,
  input  wire logic [1:0]  lag,
  output logic             slot_valid,
  output logic             slot_done,
  output logic [4:0]       done_slot
);
  logic [1:0] cnt_r;
  logic       busy_r;
  assign slot_valid = valid_map[slot_index];
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      cnt_r <= 2'h0;
      slot_done <= 1'b0;
      done_slot <= 5'h00;
    end else begin
      slot_done <= 1'b0;
      if (slot_go) begin
        busy_r <= 1'b1;
        cnt_r <= lag;
        done_slot <= slot_index;
      end else if (busy_r && cnt_r == 2'h0) begin
        busy_r <= 1'b0;
        slot_done <= 1'b1;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 2'h1;
      end else begin
        // Idle slot number wanders so nothing leans on a stale value
        done_slot <= ~done_slot;
      end
    end
  end
endmodule // sched_model

// ===== tb/tb_top.sv
// Testbench: registers, port status fields and scan walker
`timescale 1ns/1ps
module tb_top;
  localparam logic [11:0] A_PSC = usb_port_iso_pkg::PORT_STATUS_CONTROL_OFS;
  localparam logic [11:0] A_DONE = usb_port_iso_pkg::ISO_COMPLETION_MAP_OFS;
  localparam logic [11:0] A_BYP = usb_port_iso_pkg::ISO_BYPASS_MAP_OFS;
  localparam logic [11:0] A_FIN = usb_port_iso_pkg::ISO_FINAL_SLOT_MAP_OFS;
  localparam logic [11:0] A_CFG = usb_port_iso_pkg::ROUTING_CONFIG_REG_OFS;
  logic        ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        ind_cap = 1'b0, pwr_cap = 1'b0, scan_start = 1'b0, err;
  logic        pready, pslverr, slot_valid, slot_done, slot_go, scan_wrap;
  logic        handoff, vbus, link_en, cfg_done;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, w, r, fin, byp, vm, ex, valid_map = 32'h0;
  logic [31:0] seed = 32'h0000fe55;
  logic [4:0]  done_slot, slot_index;
  logic [3:0]  test_sel;
  logic [1:0]  ind = 2'h0, ind_o, lag = 2'h0;
  int          mismatches = 0, comparisons = 0, gos, n;
  usb_port_iso_pkg::line_in_t line_in = '0;
  always #2 ref_clk = ~ref_clk;
  // Links are never followed, so no link aims at a bypassed or late slot
  usb_port_status_iso_ptd_maps #(.SLOTS(32)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_in(line_in), .indicator_capable(ind_cap), .power_switch_capable(pwr_cap),
    .slot_valid(slot_valid), .next_descriptor_link(5'h00), .link_follow(1'b0),
    .slot_done(slot_done), .done_slot(done_slot), .scan_start(scan_start), .slot_go(slot_go),
    .slot_index(slot_index), .port_test_select(test_sel), .indicator_drive_field(ind_o),
    .companion_handoff_flag(handoff), .vbus_switch_bit(vbus), .link_enable(link_en),
    .config_done_bit(cfg_done), .scan_wrap(scan_wrap));
  sched_model sched (.ref_clk(ref_clk), .sys_rst(sys_rst), .slot_go(slot_go),
    .slot_index(slot_index), .valid_map(valid_map), .lag(lag), .slot_valid(slot_valid),
    .slot_done(slot_done), .done_slot(done_slot));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] psc_exp(input logic [31:0] v, input logic [1:0] id,
      input usb_port_iso_pkg::line_in_t l);
    logic [31:0] e;
    e = {12'h000, v[19:16], 2'b00, v[13:12], l.dp, l.dm, 10'h000};
    if (v[12]) begin
      e[15:14] = id;
      e[8:6] = {l.bus_reset, l.sleep, l.resume};
      e[2] = v[2];
      e[0] = l.attach;
    end
    return e;
  endfunction
  task automatic give_verdict();
    $display("Counts: %0d compared, %0d mismatched", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  // Hold the whole request until ready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge ref_clk); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin mismatches++; give_verdict(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  initial begin
    cyc(3);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    apb(0, A_DONE, 0); chk(rd, 32'h0);
    apb(0, A_BYP, 0); chk(rd, 32'hffffffff);
    apb(0, A_FIN, 0); chk(rd, 32'h0);
    apb(0, A_PSC, 0); chk(rd, 32'h00002000);
    apb(0, 12'h200, 0); chk({rd, err}, 33'h1);
    $display("test done: reset values");
    for (int v = 3; v < 6; v++) begin
      apb(1, A_CFG, v & 1); cyc(2); chk({cfg_done, handoff}, {v[0], !v[0]});
    end
    apb(1, A_PSC, 32'h1000); line_in.attach <= 1'b1; cyc(3);
    apb(0, A_PSC, 0); chk(rd[1:0], 2'b11);
    for (int i = 0; i < 16; i++) begin
      r = rnd(); w = (r & 32'h000fd004) | 32'h2; ind_cap <= r[20]; pwr_cap <= r[21];
      line_in <= {r[24], r[25], 1'b1, r[26], r[27], r[28]}; cyc(2);
      apb(1, A_PSC, w); if (r[20]) ind = w[15:14]; cyc(2);
      apb(0, A_PSC, 0); chk(rd, psc_exp(w, ind, line_in));
      chk({test_sel, vbus, link_en, ind_o}, {w[19:16], w[12], w[12] & w[2], ind});
      apb(0, usb_port_iso_pkg::STRUCTURAL_PARAMS_OFS, 0);
      chk(rd, {15'h0000, r[20], 11'h000, r[21], 4'h0});
    end
    $display("test done: port status");
    for (int i = 0; i < 4; i++) begin
      fin = (i == 3) ? 32'h0 : 32'h1 << i; byp = rnd() & rnd(); vm = rnd();
      valid_map <= vm; lag <= i[1:0];
      apb(1, A_BYP, byp); apb(1, A_FIN, fin); apb(0, A_FIN, 0); chk(rd, fin);
      ex = vm & ~byp & ((fin == 0) ? 32'hffffffff : (fin << 1) - 1); gos = 0; n = 0;
      scan_start <= 1'b1; @(posedge ref_clk); scan_start <= 1'b0;
      do begin @(posedge ref_clk); n++; gos += slot_go; end while (!scan_wrap && n < 400);
      if (n >= 400) begin mismatches++; give_verdict(); end
      cyc(2); chk(gos, $countones(ex));
      apb(0, A_DONE, 0); chk(rd, ex);
      apb(0, A_DONE, 0); chk(rd, 32'h0);
    end
    $display("test done: scan walker");
    sys_rst <= 1'b1; cyc(2); sys_rst <= 1'b0; @(posedge ref_clk);
    apb(0, A_BYP, 0); chk(rd, 32'hffffffff);
    apb(0, A_PSC, 0); chk(rd & 32'hfffff3ff, 32'h00002000);
    $display("test done: second reset");
    give_verdict();
  end
endmodule // tb_top
